// ---- logic/ptw0_pkg.sv ----
// Purpose: Shared constants and carriers for the PCI target window 0 configuration block.
// Assumes: Registers sit at byte addresses on a 12-bit register port.
// Notes:   Every offset and field position lives here, with the multi-bit and space reset values; single-bit enables reset to 0 in the block.

`default_nettype none

package ptw0_pkg;

    // ============================================================
    // Register map
    // ============================================================
    localparam int          ADDR_W              = 12;
    localparam logic [11:0] CONTROL_OFFSET      = 12'h100; // target_window0_control
    localparam logic [11:0] ADDRESS_OFFSET      = 12'h104; // target_window0_address

    // ============================================================
    // Control register field positions
    // ============================================================
    localparam int IMAGE_ON_BIT        = 31;
    localparam int SIZE_LSB            = 24;  // window_size_code [27:24]
    localparam int PREFETCH_BIT        = 23;
    localparam int BURST_WRITE_BIT     = 22;
    localparam int BYTE_FLIP_BIT       = 20;
    localparam int TXN_CODE_LSB        = 12;  // local_txn_code [15:12]
    localparam int PORT_WIDTH_LSB      = 10;  // target_port_width [11:10]
    localparam int POSTED_BIT          = 7;
    localparam int SPACE_BIT           = 6;

    // ============================================================
    // Address register field positions
    // ============================================================
    localparam int BASE_LSB            = 16;  // Base address [31:16]
    localparam int TRANS_LSB           = 0;   // translated_upper [15:0]
    localparam int UPPER_LSB           = 16;  // First compared PCI address line

    // ============================================================
    // Reset values and encodings
    // ============================================================
    localparam logic [3:0]  SIZE_RESET         = 4'h0;
    localparam logic        SPACE_RESET        = 1'b0;
    localparam logic [15:0] BASE_RESET         = 16'h0000;
    localparam logic [15:0] TRANS_RESET        = 16'h0000;
    localparam logic [3:0]  TXN_CODE_RESET     = 4'h0;
    localparam logic [1:0]  PORT_WIDTH_RESET   = 2'h0;
    localparam logic        SPACE_MEMORY       = 1'b0;
    localparam logic        SPACE_IO           = 1'b1;
    localparam logic [1:0]  PORT_32BIT         = 2'h0;
    localparam logic [1:0]  PORT_8BIT          = 2'h1;
    localparam logic [1:0]  PORT_16BIT         = 2'h2;
    localparam logic [1:0]  PORT_RESERVED      = 2'h3;
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // ============================================================
    // Carriers
    // ============================================================
    // One PCI address phase offered to the window
    typedef struct packed {
        logic        valid;     // One-cycle strobe
        logic        is_io;     // 1 = I/O space cycle
        logic        is_write;  // 1 = write cycle
        logic [31:0] addr;      // PCI address lines
    } ptw0_req_type;

    // Decode answer for one address phase
    typedef struct packed {
        logic        valid;       // One-cycle strobe
        logic        hit;         // Window claims the cycle
        logic        posted;      // Write may be posted
        logic        prefetch;    // Read may prefetch
        logic        burst_write; // Write may burst
        logic        byte_order;  // Effective local byte order
        logic [3:0]  txn_code;    // Local transaction code
        logic [1:0]  port_width;  // Local destination port width
        logic [31:0] local_addr;  // Translated local-bus address
    } ptw0_attr_type;

endpackage : ptw0_pkg

`default_nettype wire

// ---- logic/ptw0_config.sv ----
// Purpose: Control and address registers of PCI target window 0, plus its address decode.
// Assumes: Request, preload and base-config inputs come from logic on mclk_in;
//          the PCI reset and hold-off strap arrive on pins and are synchronised here.
// Notes:   Answers appear one cycle after the request strobe.

`timescale 1ns/1ns
`default_nettype none

module ptw0_config (
    // Clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    input  wire logic                  pci_rst_in,
    // Power-up strap pin
    input  wire logic                  pci_hold_off_strap_in,
    // Register port
    input  wire logic [11:0]           reg_addr_in,
    input  wire logic [31:0]           reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [31:0]           reg_rdata_out,
    // Serial EEPROM preload
    input  wire logic                  eeprom_load_in,
    input  wire logic [3:0]            eeprom_window_size_code_in,
    input  wire logic                  eeprom_space_select_in,
    input  wire logic                  eeprom_base_cfg_on_in,
    // Base address configuration register of the PCI side
    input  wire logic [15:0]           image0_base_cfg_addr_in,
    input  wire logic                  image0_base_cfg_space_in,
    output logic                       image0_base_cfg_on_out,
    // Global byte order from the misc control register
    input  wire logic                  local_byte_order_in,
    // Address phase decode
    input  wire ptw0_pkg::ptw0_req_type pci_req_in,
    output ptw0_pkg::ptw0_attr_type    attr_out
);

    // ============================================================
    // Pin synchronisers
    // ============================================================
    logic pci_rst_meta_q;    // First stage, read only by the second
    logic pci_rst_q;         // Synchronised PCI reset
    logic strap_meta_q;      // First stage, read only by the second
    logic strap_sync_q;      // Synchronised hold-off strap

    // Two flops per pin; nothing reads the first stage except the second
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pci_rst_meta_q <= 1'b0;
            pci_rst_q      <= 1'b0;
            strap_meta_q   <= 1'b0;
            strap_sync_q   <= 1'b0;
        end else begin
            pci_rst_meta_q <= pci_rst_in;
            pci_rst_q      <= pci_rst_meta_q;
            strap_meta_q   <= pci_hold_off_strap_in;
            strap_sync_q   <= strap_meta_q;
        end
    end

    // ============================================================
    // Strap latch and preload state
    // ============================================================
    logic strap_held_q;      // Strap level caught during PCI reset
    logic preloaded_q;       // Size and space came from the EEPROM
    logic base_cfg_bit_q;    // EEPROM enable bit for the base-config register

    // Strap follows the pin while PCI reset is active, then freezes
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            strap_held_q <= 1'b0;
        end else if (pci_rst_q) begin
            strap_held_q <= strap_sync_q;
        end
    end

    // Preload marks the fields as EEPROM-owned until the next reset
    always_ff @(posedge mclk_in) begin
        if (rst_in || pci_rst_q) begin
            preloaded_q    <= 1'b0;
            base_cfg_bit_q <= 1'b0;
        end else if (eeprom_load_in) begin
            preloaded_q    <= 1'b1;
            base_cfg_bit_q <= eeprom_base_cfg_on_in;
        end
    end

    // Base-config register lives only with EEPROM bit or latched strap
    logic base_cfg_on;
    assign base_cfg_on = base_cfg_bit_q | strap_held_q;

    // Strap overrides the read-only state of preloaded fields
    logic size_writable;
    assign size_writable = ~preloaded_q | strap_held_q;

    // ============================================================
    // Write decode
    // ============================================================
    logic wr_control;
    logic wr_address;
    assign wr_control = reg_wr_in && (reg_addr_in == ptw0_pkg::CONTROL_OFFSET);
    assign wr_address = reg_wr_in && (reg_addr_in == ptw0_pkg::ADDRESS_OFFSET);

    // ============================================================
    // Fields reset by the general reset
    // ============================================================
    logic       image_on_q;          // Window enable
    logic       prefetch_read_on_q;  // Prefetch reads allowed
    logic       burst_write_on_q;    // Burst writes allowed
    logic       byte_order_flip_q;   // Invert global byte order
    logic [3:0] local_txn_code_q;    // Local transaction code
    logic [1:0] target_port_width_q; // Local destination port width
    logic       posted_write_on_q;   // Posting allowed
    logic [15:0] translated_upper_q; // Translation address

    // Plain read/write control fields
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            image_on_q          <= 1'b0;
            prefetch_read_on_q  <= 1'b0;
            burst_write_on_q    <= 1'b0;
            byte_order_flip_q   <= 1'b0;
            local_txn_code_q    <= ptw0_pkg::TXN_CODE_RESET;
            target_port_width_q <= ptw0_pkg::PORT_WIDTH_RESET;
            posted_write_on_q   <= 1'b0;
        end else if (wr_control) begin
            image_on_q          <= reg_wdata_in[ptw0_pkg::IMAGE_ON_BIT];
            prefetch_read_on_q  <= reg_wdata_in[ptw0_pkg::PREFETCH_BIT];
            burst_write_on_q    <= reg_wdata_in[ptw0_pkg::BURST_WRITE_BIT];
            byte_order_flip_q   <= reg_wdata_in[ptw0_pkg::BYTE_FLIP_BIT];
            local_txn_code_q    <= reg_wdata_in[ptw0_pkg::TXN_CODE_LSB +: 4];
            target_port_width_q <= reg_wdata_in[ptw0_pkg::PORT_WIDTH_LSB +: 2];
            posted_write_on_q   <= reg_wdata_in[ptw0_pkg::POSTED_BIT];
        end
    end

    // Translation address is untouched by the EEPROM
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            translated_upper_q <= ptw0_pkg::TRANS_RESET;
        end else if (wr_address) begin
            translated_upper_q <= reg_wdata_in[ptw0_pkg::TRANS_LSB +: 16];
        end
    end

    // ============================================================
    // Fields reset by PCI reset
    // ============================================================
    logic [3:0]  window_size_code_q; // Window size code
    logic        space_sel_own_q;    // Space bit held locally
    logic [15:0] base_own_q;         // Base address held locally

    // Size and space: zero at reset, loaded by EEPROM, written when allowed.
    // General reset also clears them so they never start undefined.
    always_ff @(posedge mclk_in) begin
        if (rst_in || pci_rst_q) begin
            window_size_code_q <= ptw0_pkg::SIZE_RESET;
            space_sel_own_q    <= ptw0_pkg::SPACE_RESET;
        end else if (eeprom_load_in) begin
            window_size_code_q <= eeprom_window_size_code_in;
            space_sel_own_q    <= eeprom_space_select_in;
        end else if (wr_control && size_writable) begin
            window_size_code_q <= reg_wdata_in[ptw0_pkg::SIZE_LSB +: 4];
            space_sel_own_q    <= reg_wdata_in[ptw0_pkg::SPACE_BIT];
        end
    end

    // Local base copy only matters while the base-config register is absent
    always_ff @(posedge mclk_in) begin
        if (rst_in || pci_rst_q) begin
            base_own_q <= ptw0_pkg::BASE_RESET;
        end else if (wr_address && !base_cfg_on) begin
            base_own_q <= reg_wdata_in[ptw0_pkg::BASE_LSB +: 16];
        end
    end

    // Effective base mirrors the PCI config side when it exists; the space bit does so only after a preload.
    // The EEPROM copy is only the reset state; the config bit wins afterwards.
    logic        space_select;
    logic [15:0] base_addr;
    assign space_select = (preloaded_q && base_cfg_on) ? image0_base_cfg_space_in
                                                       : space_sel_own_q;
    assign base_addr    = base_cfg_on ? image0_base_cfg_addr_in : base_own_q;

    // ============================================================
    // Register read
    // ============================================================
    logic [31:0] control_word;
    logic [31:0] address_word;
    logic [31:0] reg_rdata_q;

    // Reserved bits read as zero
    always_comb begin
        control_word = ptw0_pkg::READ_ZERO;
        control_word[ptw0_pkg::IMAGE_ON_BIT]          = image_on_q;
        control_word[ptw0_pkg::SIZE_LSB +: 4]         = window_size_code_q;
        control_word[ptw0_pkg::PREFETCH_BIT]          = prefetch_read_on_q;
        control_word[ptw0_pkg::BURST_WRITE_BIT]       = burst_write_on_q;
        control_word[ptw0_pkg::BYTE_FLIP_BIT]         = byte_order_flip_q;
        control_word[ptw0_pkg::TXN_CODE_LSB +: 4]     = local_txn_code_q;
        control_word[ptw0_pkg::PORT_WIDTH_LSB +: 2]   = target_port_width_q;
        control_word[ptw0_pkg::POSTED_BIT]            = posted_write_on_q;
        control_word[ptw0_pkg::SPACE_BIT]             = space_select;
        address_word = {base_addr, translated_upper_q};
    end

    // Read data stands in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_q <= ptw0_pkg::READ_ZERO;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ptw0_pkg::CONTROL_OFFSET: begin
                    reg_rdata_q <= control_word;
                end
                ptw0_pkg::ADDRESS_OFFSET: begin
                    reg_rdata_q <= address_word;
                end
                default: begin
                    reg_rdata_q <= ptw0_pkg::READ_ZERO;
                end
            endcase
        end else begin
            reg_rdata_q <= ptw0_pkg::READ_ZERO;
        end
    end

    // ============================================================
    // Address compare and translation
    // ============================================================
    logic [15:0] line_compared;  // Upper line i takes part in the compare
    logic [15:0] line_match;     // Compare result per upper line
    logic [15:0] upper_out;      // Local upper address lines

    // Line 16+i is compared when i is at or above the size code, so code 0
    // compares AD31..AD16 and code 15 only AD31. Compared lines are replaced
    // by the translation; the lines below pass through untouched.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_line
            assign line_compared[gi] = (4'(gi) >= window_size_code_q);
            assign line_match[gi]    = ~line_compared[gi] ||
                (pci_req_in.addr[ptw0_pkg::UPPER_LSB + gi] == base_addr[gi]);
            assign upper_out[gi]     = line_compared[gi] ? translated_upper_q[gi]
                : pci_req_in.addr[ptw0_pkg::UPPER_LSB + gi];
        end
    endgenerate

    // Window claims a cycle only when enabled, in its own space, and on match
    logic space_ok;
    logic hit;
    assign space_ok = (pci_req_in.is_io == (space_select == ptw0_pkg::SPACE_IO));
    assign hit      = image_on_q && space_ok && (&line_match);

    // ============================================================
    // Decode answer register
    // ============================================================
    ptw0_pkg::ptw0_attr_type attr_q;

    // Answer one cycle after each request; strobe is a single cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            attr_q <= '0;
        end else begin
            attr_q.valid       <= pci_req_in.valid;
            attr_q.hit         <= pci_req_in.valid && hit;
            // I/O writes never post, whatever the enable says
            attr_q.posted      <= pci_req_in.valid && hit && posted_write_on_q &&
                                  pci_req_in.is_write && !pci_req_in.is_io;
            attr_q.prefetch    <= pci_req_in.valid && hit && prefetch_read_on_q &&
                                  !pci_req_in.is_write;
            attr_q.burst_write <= pci_req_in.valid && hit && burst_write_on_q &&
                                  pci_req_in.is_write;
            attr_q.byte_order  <= local_byte_order_in ^ byte_order_flip_q;
            attr_q.txn_code    <= local_txn_code_q;
            // Reserved width code passes as is; the local master must not use it
            attr_q.port_width  <= target_port_width_q;
            attr_q.local_addr  <= {upper_out, pci_req_in.addr[15:0]};
        end
    end

    // Base-config presence flag for the PCI configuration space
    logic base_cfg_on_q;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            base_cfg_on_q <= 1'b0;
        end else begin
            base_cfg_on_q <= base_cfg_on;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign reg_rdata_out          = reg_rdata_q;
    assign attr_out               = attr_q;
    assign image0_base_cfg_on_out = base_cfg_on_q;

endmodule // ptw0_config

`default_nettype wire

// ---- sim/ptw0_pci_master.sv ----
// Purpose: PCI master model that offers address phases to target window 0.
// Assumes: Each phase is launched by a non-blocking change just after a rising edge.
// Notes:   After a phase the bus is released, so it shows inverted lines, not stale ones.
`timescale 1ns/1ns
`default_nettype none
module ptw0_pci_master (
    // Clock
    input  wire logic                  mclk_in,
    // Address phase toward the window
    output var ptw0_pkg::ptw0_req_type req_out
);
    // Idle at time zero, so the window never samples an unknown strobe
    initial req_out = '0;
    // One address phase, one cycle long, then the released bus is scrambled
    task automatic issue(input logic io, input logic wr, input logic [31:0] a);
        @(posedge mclk_in);
        req_out <= '{valid: 1'b1, is_io: io, is_write: wr, addr: a};
        @(posedge mclk_in);
        req_out <= '{valid: 1'b0, is_io: ~io, is_write: ~wr, addr: ~a};
    endtask
endmodule // ptw0_pci_master
`default_nettype wire

// ---- sim/ptw0_config_chk.sv ----
// Purpose: Port-level assertions for the window 0 configuration block.
// Assumes: One clock; general reset masks every check.
// Notes:   Field values are not visible here, so decode flags are tied to request kind.
`timescale 1ns/1ns
`default_nettype none
module ptw0_config_chk (
    // Clock and reset
    input wire logic                    mclk_in,
    input wire logic                    rst_in,
    // Register port
    input wire logic [11:0]             reg_addr_in,
    input wire logic                    reg_rd_in,
    input wire logic [31:0]             reg_rdata_out,
    // Decode
    input wire ptw0_pkg::ptw0_req_type  pci_req_in,
    input wire ptw0_pkg::ptw0_attr_type attr_out
);
    // ============================================================
    // Assertions
    // ============================================================
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_answer_next_cycle: assert property (pci_req_in.valid |=> attr_out.valid)
        else $error("decode answer missing");
    a_answer_has_cause: assert property (attr_out.valid |-> $past(pci_req_in.valid))
        else $error("decode answer without request");
    a_hit_with_answer: assert property (attr_out.hit |-> attr_out.valid)
        else $error("hit outside answer");
    a_post_mem_write: assert property (attr_out.posted |-> attr_out.hit
        && $past(pci_req_in.is_write) && !$past(pci_req_in.is_io)) else $error("bad post");
    a_prefetch_read_only: assert property (attr_out.prefetch |-> attr_out.hit
        && !$past(pci_req_in.is_write)) else $error("bad prefetch");
    a_burst_write_only: assert property (attr_out.burst_write |-> attr_out.hit
        && $past(pci_req_in.is_write)) else $error("bad burst");
    a_low_addr_pass: assert property (attr_out.valid |->
        attr_out.local_addr[15:0] == $past(pci_req_in.addr[15:0])) else $error("low lines");
    a_rdata_one_cycle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in != ptw0_pkg::CONTROL_OFFSET
        && reg_addr_in != ptw0_pkg::ADDRESS_OFFSET |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
endmodule // ptw0_config_chk
bind ptw0_config ptw0_config_chk chk_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pci_req_in(pci_req_in), .attr_out(attr_out));
`default_nettype wire

// ---- sim/tb_pci_target_window0_config.sv ----
// Purpose: Self-checking bench for the window 0 configuration block.
// Assumes: 20 MHz clock; inputs change by non-blocking assignment at rising edges.
// Notes:   Shadows of both registers predict every decode answer.
`timescale 1ns/1ns
`default_nettype none
module tb_pci_target_window0_config;
    localparam logic [31:0] MASK = 32'h8fd0_fcc0; // Implemented control bits
    localparam logic [11:0] CTL = ptw0_pkg::CONTROL_OFFSET, ADR = ptw0_pkg::ADDRESS_OFFSET;
    logic mclk_in, rst_in, pci_rst_in, pci_hold_off_strap_in, reg_wr_in, reg_rd_in;
    logic eeprom_load_in, eeprom_space_select_in, eeprom_base_cfg_on_in, local_byte_order_in;
    logic image0_base_cfg_space_in, image0_base_cfg_on_out, io, wb;
    logic [3:0]  eeprom_window_size_code_in;
    logic [11:0] reg_addr_in;
    logic [15:0] image0_base_cfg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, cs, as, raw, a;
    ptw0_pkg::ptw0_req_type  pci_req_in;
    ptw0_pkg::ptw0_attr_type attr_out;
    int err_total, checked;
    ptw0_config dut_u (.mclk_in, .rst_in, .pci_rst_in, .pci_hold_off_strap_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .eeprom_load_in,
        .eeprom_window_size_code_in, .eeprom_space_select_in, .eeprom_base_cfg_on_in,
        .image0_base_cfg_addr_in, .image0_base_cfg_space_in, .image0_base_cfg_on_out,
        .local_byte_order_in, .pci_req_in, .attr_out);
    ptw0_pci_master pm_u (.mclk_in, .req_out(pci_req_in));
    // Clock, 50 ns period
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic bad(input string m);
        err_total++;
        $display("unexpected %0t %s", $time, m);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) bad(m);
    endtask
    // Whole decode answer, strobes and fields alike
    task automatic cmp_attr(input ptw0_pkg::ptw0_attr_type got, input ptw0_pkg::ptw0_attr_type exp);
        checked++;
        if (got !== exp) bad("decode");
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge mclk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {ad, d, 1'b1};
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    // Read, then compare the masked word in the one cycle it stands
    task automatic rc(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk_in);
        {reg_addr_in, reg_rd_in} <= {ad, 1'b1};
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 cmp32(reg_rdata_out & m, e, "register read");
    endtask
    task automatic load(input logic [3:0] s, input logic sp, input logic on);
        @(posedge mclk_in);
        eeprom_load_in <= 1'b1;
        {eeprom_window_size_code_in, eeprom_space_select_in, eeprom_base_cfg_on_in} <= {s, sp, on};
        @(posedge mclk_in);
        eeprom_load_in <= 1'b0;
    endtask
    // Expected decode answer from the register shadows
    function automatic ptw0_pkg::ptw0_attr_type exp_attr(logic i, logic w, logic [31:0] ad);
        ptw0_pkg::ptw0_attr_type e;
        logic m;
        m = cs[31] && (i == cs[6]);
        e.local_addr = ad;
        for (int k = 0; k < 16; k++) begin
            if (k >= cs[27:24]) begin
                m = m && (ad[16+k] == as[16+k]);
                e.local_addr[16+k] = as[k];
            end
        end
        {e.valid, e.hit, e.posted} = {1'b1, m, m & cs[7] & w & ~i};
        {e.prefetch, e.burst_write} = {m & cs[23] & ~w, m & cs[22] & w};
        e.byte_order = local_byte_order_in ^ cs[20];
        {e.txn_code, e.port_width} = {cs[15:12], cs[11:10]};
        return e;
    endfunction
    initial begin
        #2_000_000 bad("timeout");
        summarize();
    end
    initial begin
        {rst_in, pci_rst_in, pci_hold_off_strap_in, reg_wr_in, reg_rd_in} = 5'h10;
        {eeprom_load_in, eeprom_space_select_in, eeprom_base_cfg_on_in} = 3'h0;
        {local_byte_order_in, image0_base_cfg_space_in, eeprom_window_size_code_in} = 6'h0;
        {reg_addr_in, reg_wdata_in, image0_base_cfg_addr_in} = '0;
        void'($urandom(32'h164685f3));
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        // Reset values, unmapped place
        rc(CTL, 32'hffff_ffff, 32'h0);
        rc(ADR, 32'hffff_ffff, 32'h0);
        wr(12'h108, 32'hffff_ffff);
        rc(12'h108, 32'hffff_ffff, 32'h0);
        cmp32(image0_base_cfg_on_out, 32'h0, "base config on");
        $display("test reset done");
        // Random windows and address phases; every width code and both spaces
        for (int n = 0; n < 60; n++) begin
            raw = $urandom;
            raw[31] = (n % 5 != 0);
            raw[11:10] = n[1:0];
            cs = raw & MASK;
            as = $urandom;
            if (n == 3) as[15:0] = as[31:16];
            wr(CTL, raw);
            wr(ADR, as);
            rc(CTL, 32'hffff_ffff, cs);
            rc(ADR, 32'hffff_ffff, as);
            for (int k = 0; k < 4; k++) begin
                a = $urandom;
                if (k < 3) a[31:16] = as[31:16];
                if (k == 2) a[16] = a[16] ^ (cs[27:24] != 4'h0);
                io = (k < 2) ? cs[6] : 1'($urandom);
                wb = 1'($urandom);
                @(posedge mclk_in);
                local_byte_order_in <= 1'($urandom);
                pm_u.issue(io, wb, a);
                #1 cmp_attr(attr_out, exp_attr(io, wb, a));
            end
        end
        $display("test decode done");
        // Preload: size and space locked, space mirrors base config, base follows it.
        // The EEPROM space bit differs from the config bit, so the mirror is visible.
        @(posedge mclk_in);
        image0_base_cfg_space_in <= 1'b1;
        image0_base_cfg_addr_in <= 16'($urandom);
        load(4'h5, 1'b0, 1'b1);
        wr(CTL, 32'h8040_3080);
        rc(CTL, 32'hffff_ffff, 32'h8540_30c0);
        wr(ADR, 32'h1234_5678);
        rc(ADR, 32'hffff_ffff, {image0_base_cfg_addr_in, 16'h5678});
        cmp32(image0_base_cfg_on_out, 32'h1, "base config on");
        $display("test preload done");
        // PCI reset with the hold-off strap: other fields survive, size becomes writable
        @(posedge mclk_in);
        {pci_rst_in, pci_hold_off_strap_in} <= 2'b11;
        repeat (4) @(posedge mclk_in);
        pci_rst_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        pci_hold_off_strap_in <= 1'b0;
        rc(CTL, 32'hffff_ffff, 32'h8040_3080);
        rc(ADR, 32'h0000_ffff, 32'h5678);
        load(4'h9, 1'b0, 1'b0);
        wr(CTL, 32'h8340_3080);
        rc(CTL, 32'h0f00_0000, 32'h0300_0000);
        $display("test strap done");
        // General reset clears everything
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        rc(CTL, 32'hffff_ffff, 32'h0);
        rc(ADR, 32'hffff_ffff, 32'h0);
        cmp32(image0_base_cfg_on_out, 32'h0, "base config on");
        $display("test general reset done");
        summarize();
    end
endmodule // tb_pci_target_window0_config
`default_nettype wire
